// >>> step_sequencer.sv
// Multi-reference table and step sequencer top level
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sixteen signed references, -100.0 to 100.0 percent
// - Frequency target scales by maximum frequency
// - Voltage target scales by rated motor voltage
// - PID target passes percentage unscaled
// - Digital input code selects active reference
// - Mode 0 stops after one cycle
// - Mode 1 holds final step after cycle
// - Mode 2 repeats cycles until stop
// - Negative step reference commands reverse rotation under frequency target only
// - Run modes apply only to frequency target
// - Power retention digit one resumes saved step
// - Power retention zero restarts after power-up
// - Stop retention one resumes recorded step
// - Stop retention zero restarts each start after a stop
// - Per-step ramp set zero to three
// - Reset clears state, outputs and table references, durations and ramp sets
module step_sequencer
  import step_sequencer_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Configuration
  input wire logic [1:0] i_sequence_run_mode,
  input wire logic [1:0] i_sequence_retention_select,
  input wire logic [1:0] i_target_select,
  input wire logic i_sequencer_enable,
  input wire logic [STEP_IDX_W-1:0] i_last_step,
  input wire logic [SCALE_W-1:0] i_max_frequency,
  input wire logic [SCALE_W-1:0] i_rated_voltage,
  // Table write port
  input wire logic i_table_wr_en,
  input wire logic [STEP_IDX_W-1:0] i_table_wr_idx,
  input wire logic signed [REF_W-1:0] i_table_wr_ref,
  input wire logic [DUR_W-1:0] i_table_wr_dur,
  input wire logic [RAMP_W-1:0] i_table_wr_ramp,
  // Run control, timebase and terminals (asynchronous pins)
  input wire logic i_run_cmd,
  input wire logic i_stop_cmd,
  input wire logic i_time_tick,
  input wire logic [STEP_IDX_W-1:0] i_reference_select,
  // Power-loss retention store
  input wire logic i_power_up,
  input wire logic i_power_loss,
  input wire logic [STEP_IDX_W-1:0] i_saved_step,
  input wire logic [DUR_W-1:0] i_saved_elapsed,
  output logic o_save_strobe,
  output logic [STEP_IDX_W-1:0] o_save_step,
  output logic [DUR_W-1:0] o_save_elapsed,
  // Setpoint outputs
  output logic signed [SCALE_W:0] o_setpoint,
  output logic o_reverse,
  output logic [RAMP_W-1:0] o_ramp_select,
  output logic [STEP_IDX_W-1:0] o_step,
  output logic o_running,
  output logic o_cycle_done
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;
  logic [STEP_IDX_W-1:0] sel_meta;
  logic [STEP_IDX_W-1:0] sel_sync;
  logic run_rise;
  logic stop_rise;
  logic tick_rise;
  logic run_level;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 4'h0;
      sel_meta <= 4'h0;
      sel_sync <= 4'h0;
    end else if (i_ce) begin
      pin_meta <= {i_power_loss, i_time_tick, i_stop_cmd, i_run_cmd};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      sel_meta <= i_reference_select;
      sel_sync <= sel_meta;
    end
  end

  assign run_rise = pin_sync[0] & ~pin_prev[0];
  assign stop_rise = pin_sync[1] & ~pin_prev[1];
  assign tick_rise = pin_sync[2] & ~pin_prev[2];
  assign run_level = pin_sync[0];

  // ****************************************
  // Table
  // ****************************************
  logic [STEP_IDX_W-1:0] step;
  logic [STEP_IDX_W-1:0] rd_idx;
  logic signed [REF_W-1:0] cur_ref;
  logic [DUR_W-1:0] cur_dur;
  logic [RAMP_W-1:0] cur_ramp;

  // Direct selection when the sequencer is off, otherwise the active step
  assign rd_idx = i_sequencer_enable ? step : sel_sync;

  step_table #(
    .DEPTH(NUM_STEPS)
  ) u_table (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wr_en(i_table_wr_en),
    .i_wr_idx(i_table_wr_idx),
    .i_wr_ref(i_table_wr_ref),
    .i_wr_dur(i_table_wr_dur),
    .i_wr_ramp(i_table_wr_ramp),
    .i_rd_idx(rd_idx),
    .o_rd_ref(cur_ref),
    .o_rd_dur(cur_dur),
    .o_rd_ramp(cur_ramp)
  );

  // ****************************************
  // Sequencer state machine
  // ****************************************
  seq_state_type state;
  seq_state_type next_state;
  logic [DUR_W-1:0] elapsed;
  logic [DUR_W-1:0] next_elapsed;
  logic [STEP_IDX_W-1:0] next_step;
  logic [STEP_IDX_W-1:0] kept_step;
  logic [STEP_IDX_W-1:0] next_kept_step;
  logic [DUR_W-1:0] kept_elapsed;
  logic [DUR_W-1:0] next_kept_elapsed;
  logic cycle_done;
  logic next_cycle_done;
  logic [1:0] eff_mode;
  logic step_over;
  logic settle;
  logic next_settle;
  logic power_resume;
  logic next_power_resume;

  // Voltage and PID targets have no end-of-cycle modes; they simply repeat
  assign eff_mode = (i_target_select == TGT_FREQ) ? i_sequence_run_mode : MODE_REPEAT;
  // Read data lags the step by one cycle, so the settle flag masks it
  assign step_over = ~settle & (elapsed >= cur_dur);

  always_comb begin
    next_state = state;
    next_step = step;
    next_elapsed = elapsed;
    next_kept_step = kept_step;
    next_kept_elapsed = kept_elapsed;
    next_cycle_done = cycle_done;
    next_settle = 1'b0;
    next_power_resume = power_resume;
    if (i_power_up) begin
      next_power_resume = i_sequence_retention_select[RETAIN_POWER_BIT];
      if (i_sequence_retention_select[RETAIN_POWER_BIT]) begin
        next_kept_step = i_saved_step;
        next_kept_elapsed = i_saved_elapsed;
      end else begin
        next_kept_step = 4'h0;
        next_kept_elapsed = DUR_RESET;
      end
    end
    case (state)
      ST_IDLE: begin
        if (run_rise && i_sequencer_enable) begin
          next_state = ST_RUN;
          next_settle = 1'b1;
          next_cycle_done = 1'b0;
          // One-shot resume; a coincident power-up still arms it
          next_power_resume = i_power_up && i_sequence_retention_select[RETAIN_POWER_BIT];
          if (i_sequence_retention_select[RETAIN_STOP_BIT] || power_resume) begin
            next_step = kept_step;
            next_elapsed = kept_elapsed;
          end else begin
            next_step = 4'h0;
            next_elapsed = DUR_RESET;
          end
        end
      end
      ST_RUN: begin
        if (stop_rise || !run_level) begin
          next_state = ST_IDLE;
          next_kept_step = step;
          next_kept_elapsed = elapsed;
        end else if (step_over) begin
          next_elapsed = DUR_RESET;
          next_settle = 1'b1;
          if (step >= i_last_step) begin
            next_cycle_done = 1'b1;
            if (eff_mode == MODE_STOP) begin
              next_state = ST_DONE;
              next_kept_step = 4'h0;
              next_kept_elapsed = DUR_RESET;
            end else if (eff_mode == MODE_HOLD) begin
              next_state = ST_HOLD;
            end else begin
              next_step = 4'h0;
            end
          end else begin
            next_step = step + 4'h1;
          end
        end else if (tick_rise) begin
          next_elapsed = elapsed + 16'h0001;
        end
      end
      ST_HOLD: begin
        // Final step's value and direction stay until stop
        if (stop_rise || !run_level) begin
          next_state = ST_IDLE;
          next_kept_step = 4'h0;
          next_kept_elapsed = DUR_RESET;
        end
      end
      ST_DONE: begin
        // A fresh run command is needed after a completed cycle
        if (!run_level) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      step <= 4'h0;
      elapsed <= DUR_RESET;
      kept_step <= 4'h0;
      kept_elapsed <= DUR_RESET;
      cycle_done <= 1'b0;
      settle <= 1'b0;
      power_resume <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      step <= next_step;
      elapsed <= next_elapsed;
      kept_step <= next_kept_step;
      kept_elapsed <= next_kept_elapsed;
      cycle_done <= next_cycle_done;
      settle <= next_settle;
      power_resume <= next_power_resume;
    end
  end

  // ****************************************
  // Setpoint scaling and outputs
  // ****************************************
  logic signed [SCALE_W+REF_W+1:0] product;
  logic signed [SCALE_W:0] next_setpoint;
  logic active;
  logic next_save;

  assign active = !i_sequencer_enable || (state == ST_RUN) || (state == ST_HOLD);
  // Save on the loss edge; the store is written once per event
  assign next_save = pin_sync[3] & ~pin_prev[3];

  always_comb begin
    product = '0;
    if (i_target_select == TGT_FREQ) begin
      product = $signed({1'b0, i_max_frequency}) * cur_ref;
    end else if (i_target_select == TGT_VOLT) begin
      product = $signed({1'b0, i_rated_voltage}) * cur_ref;
    end
    if (i_target_select == TGT_PID) begin
      next_setpoint = (SCALE_W+1)'(cur_ref);
    end else begin
      next_setpoint = (SCALE_W+1)'(product / $signed(PERMILLE_DIV));
    end
    if (!active) begin
      next_setpoint = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_setpoint <= '0;
      o_reverse <= 1'b0;
      o_ramp_select <= RAMP_RESET;
      o_step <= 4'h0;
      o_running <= 1'b0;
      o_cycle_done <= 1'b0;
      o_save_strobe <= 1'b0;
      o_save_step <= 4'h0;
      o_save_elapsed <= DUR_RESET;
    end else if (i_ce) begin
      o_setpoint <= next_setpoint;
      o_reverse <= active && (i_target_select == TGT_FREQ) && cur_ref[REF_W-1];
      o_ramp_select <= cur_ramp;
      o_step <= step;
      o_running <= (state == ST_RUN) || (state == ST_HOLD);
      o_cycle_done <= cycle_done;
      o_save_strobe <= next_save;
      if (next_save) begin
        o_save_step <= (state == ST_RUN) ? step : kept_step;
        o_save_elapsed <= (state == ST_RUN) ? elapsed : kept_elapsed;
      end
    end
  end
endmodule
`default_nettype wire

// >>> step_sequencer_pkg.sv
// Package: constants and types for the multi-reference step sequencer
package step_sequencer_pkg;
  // ****************************************
  // Table geometry and value limits
  // ****************************************
  localparam int unsigned NUM_STEPS = 16;
  localparam int unsigned STEP_IDX_W = 4;
  localparam int unsigned REF_W = 11;
  localparam int unsigned DUR_W = 16;
  localparam int unsigned RAMP_W = 2;
  localparam int unsigned SCALE_W = 16;
  localparam logic signed [REF_W-1:0] REF_MAX = 11'sd1000;
  localparam logic signed [REF_W-1:0] REF_MIN = -11'sd1000;
  localparam logic signed [REF_W-1:0] REF_RESET = 11'sd0;
  localparam logic [DUR_W-1:0] DUR_RESET = 16'h0000;
  localparam logic [RAMP_W-1:0] RAMP_RESET = 2'h0;
  localparam int unsigned PERMILLE_DIV = 1000;
  // ****************************************
  // Run modes, targets and state encodings
  // ****************************************
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] TGT_FREQ = 2'h0;
  localparam logic [1:0] TGT_VOLT = 2'h1;
  localparam logic [1:0] TGT_PID = 2'h2;
  localparam int unsigned RETAIN_POWER_BIT = 0;
  localparam int unsigned RETAIN_STOP_BIT = 1;
  localparam logic [1:0] RETAIN_RESET = 2'h0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DONE = 4'b1000
  } seq_state_type;
endpackage

// >>> step_table.sv
// Step table memory: reference, duration and ramp set per step
`timescale 1ns/1ps
`default_nettype none
module step_table
  import step_sequencer_pkg::*;
#(
  parameter int unsigned DEPTH = NUM_STEPS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Write port
  input wire logic i_wr_en,
  input wire logic [STEP_IDX_W-1:0] i_wr_idx,
  input wire logic signed [REF_W-1:0] i_wr_ref,
  input wire logic [DUR_W-1:0] i_wr_dur,
  input wire logic [RAMP_W-1:0] i_wr_ramp,
  // Read port, registered
  input wire logic [STEP_IDX_W-1:0] i_rd_idx,
  output logic signed [REF_W-1:0] o_rd_ref,
  output logic [DUR_W-1:0] o_rd_dur,
  output logic [RAMP_W-1:0] o_rd_ramp
);
  // ****************************************
  // Storage
  // ****************************************
  logic signed [REF_W-1:0] ref_mem [DEPTH];
  logic [DUR_W-1:0] dur_mem [DEPTH];
  logic [RAMP_W-1:0] ramp_mem [DEPTH];
  logic signed [REF_W-1:0] clamped_ref;

  // Out-of-span writes are clamped so the table never holds illegal values
  always_comb begin
    clamped_ref = i_wr_ref;
    if (i_wr_ref > REF_MAX) begin
      clamped_ref = REF_MAX;
    end else if (i_wr_ref < REF_MIN) begin
      clamped_ref = REF_MIN;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        ref_mem[i] <= REF_RESET;
        dur_mem[i] <= DUR_RESET;
        ramp_mem[i] <= RAMP_RESET;
      end
      o_rd_ref <= REF_RESET;
      o_rd_dur <= DUR_RESET;
      o_rd_ramp <= RAMP_RESET;
    end else if (i_ce) begin
      if (i_wr_en) begin
        ref_mem[i_wr_idx] <= clamped_ref;
        dur_mem[i_wr_idx] <= i_wr_dur;
        ramp_mem[i_wr_idx] <= i_wr_ramp;
      end
      o_rd_ref <= ref_mem[i_rd_idx];
      o_rd_dur <= dur_mem[i_rd_idx];
      o_rd_ramp <= ramp_mem[i_rd_idx];
    end
  end
endmodule
`default_nettype wire

// >>> step_sequencer_props.sv
// Assertion checker for the step sequencer outputs
`timescale 1ns/1ps
`default_nettype none
module step_sequencer_props
  import step_sequencer_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Configuration
  input wire logic [1:0] i_sequence_run_mode,
  input wire logic [1:0] i_target_select,
  input wire logic i_sequencer_enable,
  input wire logic [STEP_IDX_W-1:0] i_last_step,
  // Observed outputs
  input wire logic o_save_strobe,
  input wire logic signed [SCALE_W:0] o_setpoint,
  input wire logic o_reverse,
  input wire logic [STEP_IDX_W-1:0] o_step,
  input wire logic o_running,
  input wire logic o_cycle_done
);
  // ****
  // Sequences and properties
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_at_last;
    o_running && o_step == i_last_step;
  endsequence
  sequence s_wrap;
    s_at_last ##1 (o_running && o_step != i_last_step);
  endsequence
  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    i_rst && i_ce |=> !o_running && o_setpoint == '0 && o_step == '0 && !o_cycle_done)
    else $error("outputs not cleared by reset");
  AST_STEP_ORDER: assert property (
    o_running && $past(o_running) && o_step != $past(o_step)
    |-> o_step == $past(o_step) + 4'h1 || o_step == 4'h0)
    else $error("step did not ascend or wrap");
  AST_STEP_BOUND: assert property (o_running |-> o_step <= i_last_step)
    else $error("step beyond last configured step");
  AST_MODE_STOP: assert property (
    i_sequence_run_mode == MODE_STOP && i_target_select == TGT_FREQ && $rose(o_cycle_done)
    |-> ##[0:2] !o_running)
    else $error("still running after cycle in stop mode");
  AST_MODE_HOLD: assert property (
    (i_sequence_run_mode == MODE_HOLD && i_target_select == TGT_FREQ) ##0 s_at_last
    |=> o_step == i_last_step || !o_running)
    else $error("final step not held");
  AST_MODE_REPEAT: assert property (
    (i_sequence_run_mode[1] || i_target_select == TGT_VOLT) ##0 s_wrap |-> o_step == 4'h0)
    else $error("cycle did not restart at step zero");
  AST_REVERSE_FREQ: assert property (o_reverse |-> i_target_select == TGT_FREQ)
    else $error("reverse outside frequency target");
  AST_IDLE_ZERO: assert property (
    (i_sequencer_enable && !o_running) [*3] |-> o_setpoint == '0)
    else $error("setpoint not zero while idle");
  AST_SAVE_PULSE: assert property (o_save_strobe |=> !o_save_strobe)
    else $error("save strobe longer than one cycle");
endmodule
bind step_sequencer step_sequencer_props u_step_sequencer_props (.i_core_clk, .i_rst, .i_ce,
  .i_sequence_run_mode, .i_target_select, .i_sequencer_enable, .i_last_step, .o_save_strobe,
  .o_setpoint, .o_reverse, .o_step, .o_running, .o_cycle_done);
`default_nettype wire

// >>> position_store_model.sv
// Nonvolatile position store on the far side of the save port
`timescale 1ns/1ps
`default_nettype none
module position_store_model
  import step_sequencer_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Save port
  input wire logic i_save_strobe,
  input wire logic [STEP_IDX_W-1:0] i_save_step,
  input wire logic [DUR_W-1:0] i_save_elapsed,
  // Restore values
  output var logic [STEP_IDX_W-1:0] o_kept_step = 4'h0,
  output var logic [DUR_W-1:0] o_kept_elapsed = 16'h0000
);
  // Never reset: it stands for memory that outlives a power loss
  always @(posedge i_core_clk) begin
    if (i_save_strobe === 1'b1) begin
      o_kept_step <= i_save_step;
      o_kept_elapsed <= i_save_elapsed;
    end
  end
endmodule
`default_nettype wire

// >>> multi_reference_step_sequencer_tb.sv
// Self-checking testbench for the step sequencer
`timescale 1ns/1ps
`default_nettype none
module multi_reference_step_sequencer_tb
  import step_sequencer_pkg::*;
;
  typedef struct {logic signed [16:0] sp; logic [3:0] st; logic rv; logic [1:0] rp;
    logic run; logic dn;} note_type;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_sequencer_enable = 1'b1;
  logic [1:0] i_sequence_run_mode = 2'h0, i_sequence_retention_select = 2'h0;
  logic [1:0] i_target_select = 2'h0, i_table_wr_ramp = 2'h0, o_ramp_select;
  logic [3:0] i_last_step = 4'h0, i_table_wr_idx = 4'h0, i_reference_select = 4'h0;
  logic [3:0] i_saved_step, o_save_step, o_step;
  logic [15:0] i_max_frequency = 16'h1f40, i_rated_voltage = 16'h0dac;
  logic [15:0] i_table_wr_dur = 16'h0000, i_saved_elapsed, o_save_elapsed;
  logic i_table_wr_en = 1'b0, i_run_cmd = 1'b0, i_stop_cmd = 1'b0, i_time_tick = 1'b0;
  logic i_power_up = 1'b0, i_power_loss = 1'b0;
  logic o_save_strobe, o_reverse, o_running, o_cycle_done;
  logic signed [10:0] i_table_wr_ref = 11'sh0;
  logic signed [16:0] o_setpoint;
  logic signed [10:0] tref [16];
  logic [1:0] tramp [16];
  note_type notes [$];
  note_type got;
  integer seed = 32'h997e;
  int miscompares = 0, total_checks = 0;
  event snap;
  step_sequencer u_step_sequencer (.i_core_clk, .i_rst, .i_ce, .i_sequence_run_mode,
    .i_sequence_retention_select, .i_target_select, .i_sequencer_enable, .i_last_step,
    .i_max_frequency, .i_rated_voltage, .i_table_wr_en, .i_table_wr_idx, .i_table_wr_ref,
    .i_table_wr_dur, .i_table_wr_ramp, .i_run_cmd, .i_stop_cmd, .i_time_tick,
    .i_reference_select, .i_power_up, .i_power_loss, .i_saved_step, .i_saved_elapsed,
    .o_save_strobe, .o_save_step, .o_save_elapsed, .o_setpoint, .o_reverse, .o_ramp_select,
    .o_step, .o_running, .o_cycle_done);
  position_store_model u_position_store_model (.i_core_clk, .i_save_strobe(o_save_strobe),
    .i_save_step(o_save_step), .i_save_elapsed(o_save_elapsed), .o_kept_step(i_saved_step),
    .o_kept_elapsed(i_saved_elapsed));
  always #5 i_core_clk = ~i_core_clk;
  // ****
  // Helpers
  // ****
  function automatic logic signed [16:0] scale(input logic signed [10:0] r);
    int v;
    v = r;
    if (i_target_select == TGT_FREQ) v = v * int'(i_max_frequency) / 1000;
    else if (i_target_select == TGT_VOLT) v = v * int'(i_rated_voltage) / 1000;
    return v[16:0];
  endfunction
  task automatic cmp(input string nm, input logic [16:0] e, input logic [16:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic note(input logic signed [16:0] sp, input logic [3:0] st, input logic run,
    input logic dn, input logic rv);
    notes.push_back('{sp, st, rv, tramp[st], run, dn});
    -> snap;
  endtask
  // Waits bounded; a miss shows up as a wrong step or running flag
  task automatic see(input int k, input logic run, input logic dn);
    int n;
    n = 0;
    while (!(o_running === run && (!run || o_step === k[3:0])) && n < 300) begin
      @(negedge i_core_clk);
      n++;
    end
    repeat (3) @(negedge i_core_clk);
    note(run ? scale(tref[k]) : 17'sh0, k[3:0], run, dn,
      run && i_target_select == TGT_FREQ && tref[k] < 0);
  endtask
  task automatic adv(input int n);
    repeat (n) begin
      i_time_tick = 1'b1;
      repeat (2) @(negedge i_core_clk);
      i_time_tick = 1'b0;
      repeat (2) @(negedge i_core_clk);
    end
  endtask
  // Steps 1 and 2 overflow on purpose to exercise clamping
  task automatic fill();
    for (int k = 0; k < 16; k++) begin
      i_table_wr_idx = k[3:0];
      i_table_wr_ref = (k == 1) ? 11'sh3ff : (k == 2) ? 11'sh400 : 11'($random(seed) % 1001);
      i_table_wr_dur = 16'h0002;
      i_table_wr_ramp = 2'($random(seed));
      i_table_wr_en = 1'b1;
      tref[k] = (k == 1) ? 11'sd1000 : (k == 2) ? -11'sd1000 : i_table_wr_ref;
      tramp[k] = i_table_wr_ramp;
      @(negedge i_core_clk);
    end
    i_table_wr_en = 1'b0;
  endtask
  task automatic restart(input logic pw);
    i_rst = 1'b1;
    repeat (5) @(negedge i_core_clk);
    i_rst = 1'b0;
    i_power_up = pw;
    @(negedge i_core_clk);
    i_power_up = 1'b0;
    fill();
  endtask
  task automatic halt();
    i_run_cmd = 1'b0;
    repeat (8) @(negedge i_core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(snap);
      got = notes.pop_front();
      if (got.run) begin
        cmp("step", 17'(got.st), 17'(o_step));
        cmp("ramp", 17'(got.rp), 17'(o_ramp_select));
      end else begin
        cmp("cycle_done", 17'(got.dn), 17'(o_cycle_done));
      end
      cmp("setpoint", got.sp, o_setpoint);
      cmp("reverse", 17'(got.rv), 17'(o_reverse));
      cmp("running", 17'(got.run), 17'(o_running));
    end
  end
  initial begin
    #500000;
    miscompares++;
    $display("watchdog expired");
    give_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    restart(1'b0);
    note(17'sh0, 4'h0, 1'b0, 1'b0, 1'b0);
    i_last_step = 4'h3;
    i_run_cmd = 1'b1;
    for (int k = 0; k < 4; k++) begin
      see(k, 1'b1, 1'b0);
      adv(2);
    end
    see(0, 1'b0, 1'b1);
    repeat (20) @(negedge i_core_clk);
    see(0, 1'b0, 1'b1);
    halt();
    $display("finished: stop after cycle");
    i_target_select = TGT_PID;
    i_sequence_run_mode = MODE_REPEAT;
    i_last_step = 4'h2;
    i_run_cmd = 1'b1;
    for (int k = 0; k < 5; k++) begin
      see(k % 3, 1'b1, 1'b0);
      adv(2);
    end
    i_ce = 1'b0;
    repeat (10) @(negedge i_core_clk);
    i_ce = 1'b1;
    i_stop_cmd = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_stop_cmd = 1'b0;
    see(0, 1'b0, 1'b1);
    halt();
    $display("finished: repeat until stop");
    i_target_select = TGT_VOLT;
    i_sequence_run_mode = MODE_STOP;
    i_last_step = 4'h1;
    i_run_cmd = 1'b1;
    for (int k = 0; k < 3; k++) begin
      see(k % 2, 1'b1, 1'b0);
      adv(2);
    end
    halt();
    see(0, 1'b0, 1'b1);
    $display("finished: voltage target");
    i_target_select = TGT_FREQ;
    i_sequence_run_mode = MODE_HOLD;
    i_last_step = 4'h2;
    i_run_cmd = 1'b1;
    for (int k = 0; k < 3; k++) begin
      see(k, 1'b1, 1'b0);
      adv(2);
    end
    adv(2);
    see(2, 1'b1, 1'b0);
    halt();
    $display("finished: hold final step");
    i_sequence_retention_select = 2'h2;
    i_sequence_run_mode = MODE_REPEAT;
    i_last_step = 4'h3;
    i_run_cmd = 1'b1;
    for (int k = 0; k < 2; k++) begin
      see(k, 1'b1, 1'b0);
      adv(2);
    end
    see(2, 1'b1, 1'b0);
    halt();
    see(0, 1'b0, 1'b0);
    i_run_cmd = 1'b1;
    see(2, 1'b1, 1'b0);
    i_sequence_retention_select = 2'h0;
    halt();
    i_run_cmd = 1'b1;
    see(0, 1'b1, 1'b0);
    adv(2);
    see(1, 1'b1, 1'b0);
    i_sequence_retention_select = 2'h1;
    adv(1);
    i_power_loss = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_power_loss = 1'b0;
    repeat (10) @(negedge i_core_clk);
    cmp("save_step", 17'h1, 17'(o_save_step));
    cmp("save_elapsed", 17'h1, 17'(o_save_elapsed));
    halt();
    restart(1'b1);
    i_run_cmd = 1'b1;
    see(1, 1'b1, 1'b0);
    halt();
    i_sequence_retention_select = 2'h0;
    restart(1'b1);
    i_run_cmd = 1'b1;
    see(0, 1'b1, 1'b0);
    halt();
    $display("finished: retention");
    i_sequencer_enable = 1'b0;
    i_target_select = TGT_PID;
    for (int k = 1; k < 16; k += 4) begin
      i_reference_select = k[3:0];
      repeat (8) @(negedge i_core_clk);
      note(scale(tref[k]), k[3:0], 1'b0, 1'b0, 1'b0);
    end
    $display("finished: terminal selection");
    repeat (5) @(negedge i_core_clk);
    give_verdict();
  end
endmodule
`default_nettype wire
